// File: design/dsm_defines.svh
`ifndef DSM_DEFINES_SVH
`define DSM_DEFINES_SVH

// ----------------------------------------
// register offsets (byte addresses, low 12 address bits)
// ----------------------------------------
`define DSM_OFS_CFG 12'h000
`define DSM_OFS_TEST 12'h004
`define DSM_OFS_IRQW 12'h008
`define DSM_OFS_STAT 12'h00c
`define DSM_OFS_MASK 12'h010
`define DSM_RAM_BASE 12'h100
`define DSM_RAM_LAST 12'h1fc

// ----------------------------------------
// module configuration fields
// ----------------------------------------
`define DSM_CFG_STOP 15
`define DSM_CFG_FREEZE_HALT_SELECT 14
`define DSM_CFG_FREEZE_SPARE_BIT 13
`define DSM_CFG_IARB_HI 3
`define DSM_CFG_RST 16'h8000
`define DSM_CFG_MASK 32'h0000e00f

// ----------------------------------------
// interrupt level / vector word
// ----------------------------------------
`define DSM_LVQ_HI 13
`define DSM_LVQ_LO 11
`define DSM_LVS_HI 10
`define DSM_LVS_LO 8
`define DSM_VEC_RST 8'h0f
`define DSM_LVL_OFF 3'h0

// ----------------------------------------
// status / mask bits
// ----------------------------------------
`define DSM_EV_W 3
`define DSM_EV_HALT 0
`define DSM_EV_RESUME 1
`define DSM_EV_STOP 2

`endif

// File: design/dsm_pkg.sv
package dsm_pkg;
	// apb slave phase, one-hot
	typedef enum logic [1:0] {
		DSM_ST_IDLE = 2'b01,
		DSM_ST_RESP = 2'b10
	} dsm_apb_st_t;

	// which submodule owns the presented vector
	typedef enum logic {
		DSM_SRC_ASYNC = 1'b0,
		DSM_SRC_QUEUED = 1'b1
	} dsm_src_t;
endpackage

// File: design/dsm_ram.sv
`timescale 1ns/1ps
// ----------------------------------------
// queue ram, registered read port
// ----------------------------------------
module dsm_ram #(
	parameter int DW = 16,
	parameter int AW = 6
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [DW-1:0] wdata,
	input wire logic [AW-1:0] raddr,
	output logic [DW-1:0] rdata
);
	logic [DW-1:0] mem [0:(1<<AW)-1];

	// storage write, no reset so it maps to ram cells
	always_ff @(posedge pclk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	// read data out of a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata <= '0;
		end else begin
			rdata <= mem[raddr];
		end
	end
endmodule

// File: design/dsm_irq_arb.sv
`timescale 1ns/1ps
// ----------------------------------------
// request level encode and submodule priority
// ----------------------------------------
module dsm_irq_arb
	import dsm_pkg::*;
(
	input wire logic [2:0] lvl_queued,
	input wire logic [2:0] lvl_async,
	input wire logic req_queued,
	input wire logic req_async,
	output logic [7:1] lines,
	output dsm_src_t winner
);
	// level to request line, zero level gives no line
	function automatic logic [7:1] lvl_line(input logic [2:0] lvl, input logic req);
		logic [7:1] l;
		l = '0;
		if (req && lvl != 3'h0) begin
			l[lvl] = 1'b1;
		end
		return l;
	endfunction

	wire logic act_q = req_queued && (lvl_queued != 3'h0);
	wire logic act_s = req_async && (lvl_async != 3'h0);

	// queued port wins ties; higher level wins otherwise
	assign lines = lvl_line(lvl_queued, req_queued) | lvl_line(lvl_async, req_async);
	assign winner = (act_q && (!act_s || lvl_queued >= lvl_async)) ? DSM_SRC_QUEUED : DSM_SRC_ASYNC;
endmodule

// File: design/dsm_global_ctrl.sv
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`include "dsm_defines.svh"
// Notes on behaviour
// - stop bit set gates the module clock and enters low power
// - config register stays readable while stopped; others may read zero
// - ram reads not needed while stopped; ram and register writes still land
// - stop set by software write and by reset
// - freeze with halt select set halts queued port at next transfer boundary
// - spare freeze bit stores but changes nothing
// - unimplemented bits ignore writes and read zero
// - address top bit of decode comes from module map bit
// - level and vector registers are bytes sharing one word
// - one vector register serves both submodules
// - 3-bit level picks request line; 7 highest, 0 disables
// - equal nonzero levels: queued port request beats async request
// - vector bit zero supplied by module, writes ignored, reads one
// - reset loads vector with the uninitialised vector number
module dsm_global_ctrl
	import dsm_pkg::*;
#(
	parameter int ADDR_W = 24,
	parameter int RAM_AW = 6
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic freeze,
	input wire logic module_map_bit,
	input wire logic transfer_boundary,
	input wire logic queued_irq_req,
	input wire logic async_irq_req,
	output logic run_clk_en,
	output logic queued_freeze_halt,
	output logic [7:1] irq_lines,
	output logic [7:0] irq_vector,
	output logic irq
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	dsm_apb_st_t st_reg, st_next;
	logic [15:0] cfg_reg;
	logic [5:0] lvl_reg;
	logic [7:1] vec_reg;
	logic [`DSM_EV_W-1:0] stat_reg, stat_next, mask_reg, ev;
	logic halt_reg;
	logic [31:0] rdata_mux;
	logic [15:0] ram_q;
	logic [7:1] arb_lines;
	dsm_src_t arb_win;

	// ----------------------------------------
	// address decode
	// ----------------------------------------
	wire logic [11:0] ofs = paddr[11:0];
	wire logic map_ok = (paddr[ADDR_W-1] == module_map_bit);
	wire logic hit_cfg = map_ok && ofs == `DSM_OFS_CFG;
	wire logic hit_test = map_ok && ofs == `DSM_OFS_TEST;
	wire logic hit_irqw = map_ok && ofs == `DSM_OFS_IRQW;
	wire logic hit_stat = map_ok && ofs == `DSM_OFS_STAT;
	wire logic hit_mask = map_ok && ofs == `DSM_OFS_MASK;
	wire logic hit_ram = map_ok && ofs >= `DSM_RAM_BASE && ofs <= `DSM_RAM_LAST && ofs[1:0] == 2'b00;
	wire logic hit_any = hit_cfg || hit_test || hit_irqw || hit_stat || hit_mask || hit_ram;
	wire logic stopped = cfg_reg[`DSM_CFG_STOP];

	// first access cycle launches the answer; write lands one edge later
	wire logic acc_start = psel && penable && st_reg == DSM_ST_IDLE;
	wire logic wr_fire = psel && penable && pwrite && st_reg == DSM_ST_RESP && hit_any;
	wire logic [RAM_AW-1:0] ram_idx = paddr[RAM_AW+1:2];

	// ----------------------------------------
	// apb phase machine
	// ----------------------------------------
	always_comb begin
		st_next = st_reg;
		case (st_reg)
			DSM_ST_IDLE: begin
				if (acc_start) begin
					st_next = DSM_ST_RESP;
				end
			end
			DSM_ST_RESP: begin
				st_next = DSM_ST_IDLE;
			end
			default: begin
				st_next = DSM_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= DSM_ST_IDLE;
		end else begin
			st_reg <= st_next;
		end
	end

	// ----------------------------------------
	// read mux
	// ----------------------------------------
	// while stopped only the config word is promised, so the rest reads zero;
	// that keeps gated state from leaking stale values onto the bus
	always_comb begin
		rdata_mux = 32'h0;
		if (hit_cfg) begin
			rdata_mux = {16'h0, cfg_reg} & `DSM_CFG_MASK;
		end else if (stopped) begin
			rdata_mux = 32'h0;
		end else if (hit_irqw) begin
			rdata_mux = {18'h0, lvl_reg, vec_reg, 1'b1};
		end else if (hit_stat) begin
			rdata_mux = {{(32-`DSM_EV_W){1'b0}}, stat_reg};
		end else if (hit_mask) begin
			rdata_mux = {{(32-`DSM_EV_W){1'b0}}, mask_reg};
		end else if (hit_ram) begin
			rdata_mux = {16'h0, ram_q};
		end
	end

	// answer flops: pready one cycle after the first access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end else begin
			pready <= acc_start;
			pslverr <= acc_start && !hit_any;
			prdata <= (acc_start && !pwrite) ? rdata_mux : 32'h0;
		end
	end

	// ----------------------------------------
	// configuration, level and vector registers
	// ----------------------------------------
	// writes land whether or not stop is set; test word is write-ignored
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_reg <= `DSM_CFG_RST;
			lvl_reg <= 6'h0;
			vec_reg <= 7'(`DSM_VEC_RST >> 1);
			mask_reg <= '0;
		end else if (wr_fire) begin
			if (hit_cfg && pstrb[1]) begin
				cfg_reg[15:8] <= pwdata[15:8] & 8'he0;
			end
			if (hit_cfg && pstrb[0]) begin
				cfg_reg[7:0] <= pwdata[7:0] & 8'h0f;
			end
			if (hit_irqw && pstrb[1]) begin
				lvl_reg <= pwdata[`DSM_LVQ_HI:`DSM_LVS_LO];
			end
			if (hit_irqw && pstrb[0]) begin
				vec_reg <= pwdata[7:1];
			end
			if (hit_mask && pstrb[0]) begin
				mask_reg <= pwdata[`DSM_EV_W-1:0];
			end
		end
	end

	// ----------------------------------------
	// queue ram
	// ----------------------------------------
	dsm_ram #(
		.DW(16),
		.AW(RAM_AW)
	) u_ram (
		.pclk(pclk),
		.presetn(presetn),
		.we(wr_fire && hit_ram && pstrb[1:0] == 2'b11),
		.waddr(ram_idx),
		.wdata(pwdata[15:0]),
		.raddr(ram_idx),
		.rdata(ram_q)
	);

	// ----------------------------------------
	// freeze halt and clock gate
	// ----------------------------------------
	// the spare freeze bit is deliberately not read here
	wire logic halt_set = freeze && cfg_reg[`DSM_CFG_FREEZE_HALT_SELECT] && transfer_boundary && !stopped;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			halt_reg <= 1'b0;
			run_clk_en <= 1'b0;
			queued_freeze_halt <= 1'b0;
		end else begin
			if (!freeze) begin
				halt_reg <= 1'b0;
			end else if (halt_set) begin
				halt_reg <= 1'b1;
			end
			run_clk_en <= !stopped;
			queued_freeze_halt <= halt_reg;
		end
	end

	// ----------------------------------------
	// event status and interrupt
	// ----------------------------------------
	// a set in the same cycle as a write-one clear wins
	assign ev[`DSM_EV_HALT] = halt_set && !halt_reg;
	assign ev[`DSM_EV_RESUME] = halt_reg && !freeze;
	assign ev[`DSM_EV_STOP] = wr_fire && hit_cfg && pstrb[1] && pwdata[`DSM_CFG_STOP] && !stopped;
	assign stat_next = (stat_reg & ~((wr_fire && hit_stat && pstrb[0]) ? pwdata[`DSM_EV_W-1:0] : '0)) | ev;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stat_reg <= '0;
			irq <= 1'b0;
		end else begin
			stat_reg <= stat_next;
			irq <= |(stat_next & mask_reg);
		end
	end

	// ----------------------------------------
	// serial request arbitration
	// ----------------------------------------
	dsm_irq_arb u_arb (
		.lvl_queued(lvl_reg[5:3]),
		.lvl_async(lvl_reg[2:0]),
		.req_queued(queued_irq_req),
		.req_async(async_irq_req),
		.lines(arb_lines),
		.winner(arb_win)
	);

	// bit zero names the source, upper bits are shared
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_lines <= '0;
			irq_vector <= `DSM_VEC_RST;
		end else begin
			irq_lines <= arb_lines;
			irq_vector <= {vec_reg, arb_win};
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	sequence s_frz_armed;
		freeze && cfg_reg[`DSM_CFG_FREEZE_HALT_SELECT] && !stopped;
	endsequence

	sequence s_boundary_hit;
		transfer_boundary ##1 halt_reg;
	endsequence

	a_stop_gates_clk: assert property (@(posedge pclk) disable iff (!presetn)
		stopped |=> !run_clk_en) else $error("clock enable high while stopped");

	a_cfg_read_stop: assert property (@(posedge pclk) disable iff (!presetn)
		(acc_start && !pwrite && hit_cfg && stopped) |=> pready && prdata[`DSM_CFG_STOP])
		else $error("config read while stopped lost stop bit");

	a_ram_write_stop: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_fire && hit_ram && stopped && pstrb == 4'hf) |-> u_ram.we)
		else $error("ram write dropped while stopped");

	a_freeze_halt: assert property (@(posedge pclk) disable iff (!presetn)
		s_frz_armed and transfer_boundary |-> s_boundary_hit ##1 queued_freeze_halt)
		else $error("queued port did not halt at boundary");

	a_spare_no_effect: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(halt_reg) |-> $past(cfg_reg[`DSM_CFG_FREEZE_HALT_SELECT]))
		else $error("halt without halt select");

	a_unimpl_zero: assert property (@(posedge pclk) disable iff (!presetn)
		(acc_start && !pwrite && hit_cfg) |=> (prdata & ~`DSM_CFG_MASK) == 32'h0)
		else $error("unimplemented config bits read nonzero");

	a_map_decode: assert property (@(posedge pclk) disable iff (!presetn)
		(acc_start && paddr[ADDR_W-1] != module_map_bit) |=> pready && pslverr)
		else $error("wrong module map accepted");

	a_vec_low_one: assert property (@(posedge pclk) disable iff (!presetn)
		(acc_start && !pwrite && hit_irqw && !stopped) |=> prdata[0])
		else $error("vector low bit read zero");

	a_tie_queued: assert property (@(posedge pclk) disable iff (!presetn)
		(queued_irq_req && async_irq_req && lvl_reg[5:3] == lvl_reg[2:0] && lvl_reg[2:0] != 3'h0)
		|=> irq_vector[0]) else $error("tie not won by queued port");

	a_level_line: assert property (@(posedge pclk) disable iff (!presetn)
		(queued_irq_req && lvl_reg[5:3] == 3'h7) |=> irq_lines[7])
		else $error("level seven line missing");

	a_resume: assert property (@(posedge pclk) disable iff (!presetn)
		(halt_reg && !freeze) |=> !halt_reg ##1 !queued_freeze_halt)
		else $error("queued port stayed halted after freeze release");
endmodule

// File: testbench/dsm_qport_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// queued port stand-in: boundaries and requests
// ----------------------------------------
module dsm_qport_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic halt,
	input wire logic want_q,
	input wire logic want_a,
	output logic boundary,
	output logic req_q,
	output logic req_a
);
	logic [1:0] cnt_reg;
	// a transfer ends every four cycles; a halted port makes no boundaries
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_reg <= 2'h0;
		end else if (!halt) begin
			cnt_reg <= cnt_reg + 2'h1;
		end
	end
	assign boundary = !halt && cnt_reg == 2'h3;
	// requests follow the bench's wishes
	assign req_q = want_q;
	assign req_a = want_a;
endmodule

// File: testbench/tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_total++; $display("mismatch %0t value", $time); end end
module tb;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [23:0] paddr = 24'h0;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic [3:0] pstrb = 4'hf;
	logic pready, pslverr, e, freeze = 1'b0, mm = 1'b1, bnd, rq, ra, wq = 1'b0, wa = 1'b0;
	logic run_clk_en, halt, irq;
	logic [7:1] lines;
	logic [7:0] vec;
	int err_total = 0, compares = 0;
	// ----------------------------------------
	// clock, design and queued port stand-in
	// ----------------------------------------
	always #5 pclk = ~pclk;
	dsm_global_ctrl dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.freeze(freeze), .module_map_bit(mm), .transfer_boundary(bnd), .queued_irq_req(rq),
		.async_irq_req(ra), .run_clk_en(run_clk_en), .queued_freeze_halt(halt), .irq_lines(lines),
		.irq_vector(vec), .irq(irq));
	dsm_qport_model q_u (.pclk(pclk), .presetn(presetn), .halt(halt), .want_q(wq), .want_a(wa),
		.boundary(bnd), .req_q(rq), .req_a(ra));
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic print_verdict;
		if (err_total == 0 && compares > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// one apb transfer; top address bit from a, request held until pready
	// pready and prdata are read at the rising edge itself, before the design's flops update,
	// so the request drops at the very edge that completes it and no second access is launched
	task automatic apb(input logic w, input logic a, input logic [11:0] ofs, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {a, 11'h0, ofs};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready === 1'b1) begin
			r = prdata;
			e = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end else begin
			err_total++;
			print_verdict();
		end
	endtask
	task automatic rd(input logic [11:0] ofs, input logic [31:0] x);
		apb(1'b0, mm, ofs, 32'h0);
		`CHK(r, x)
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset_stop;
		`CHK(run_clk_en, 1'b0)
		`CHK(vec, 8'h0f)
		rd(12'h000, 32'h0000_8000);
		rd(12'h008, 32'h0);
		apb(1'b1, mm, 12'h010, 32'h0000_0001);
		apb(1'b1, mm, 12'h104, 32'h0000_a5c3);
		rd(12'h104, 32'h0);
		apb(1'b1, mm, 12'h000, 32'hffff_7fff);
		rd(12'h000, 32'h0000_600f);
		`CHK(run_clk_en, 1'b1)
		rd(12'h010, 32'h0000_0001);
		rd(12'h104, 32'h0000_a5c3);
		rd(12'h004, 32'h0);
		apb(1'b0, mm, 12'h020, 32'h0);
		`CHK(e, 1'b1)
		apb(1'b0, ~mm, 12'h000, 32'h0);
		`CHK(e, 1'b1)
	endtask
	// level and vector word, arbitration between the two submodules
	task automatic t_levels;
		int l;
		apb(1'b1, mm, 12'h008, 32'h0000_2d40);
		rd(12'h008, 32'h0000_2d41);
		wq <= 1'b1;
		wa <= 1'b1;
		repeat (3) @(negedge pclk);
		`CHK(lines, 7'h10)
		`CHK(vec, 8'h41)
		@(posedge pclk) wq <= 1'b0;
		repeat (3) @(negedge pclk);
		`CHK(vec, 8'h40)
		@(posedge pclk) wa <= 1'b0;
		wq <= 1'b1;
		for (l = 0; l < 8; l++) begin
			apb(1'b1, mm, 12'h008, {18'h0, l[2:0], 11'h040});
			repeat (3) @(negedge pclk);
			`CHK(lines, (l == 0) ? 7'h0 : 7'(1 << (l - 1)))
		end
		@(posedge pclk) wq <= 1'b0;
	endtask
	// freeze halts at a boundary, raises the interrupt, resumes on release
	task automatic t_freeze;
		int n;
		apb(1'b1, mm, 12'h000, 32'h0000_4001);
		@(posedge pclk) freeze <= 1'b1;
		for (n = 0; n < 20 && halt !== 1'b1; n++) @(negedge pclk);
		`CHK(halt, 1'b1)
		@(negedge pclk);
		`CHK(irq, 1'b1)
		rd(12'h00c, 32'h0000_0001);
		apb(1'b1, mm, 12'h00c, 32'h0000_0001);
		@(negedge pclk);
		`CHK(irq, 1'b0)
		@(posedge pclk) freeze <= 1'b0;
		repeat (4) @(negedge pclk);
		`CHK(halt, 1'b0)
		`CHK(irq, 1'b0)
		rd(12'h00c, 32'h0000_0002);
		apb(1'b1, mm, 12'h00c, 32'h0000_0002);
	endtask
	// software halts the port, waits for the acknowledge, then sets stop
	task automatic t_sw_stop;
		int n;
		apb(1'b1, mm, 12'h010, 32'h0000_0004);
		apb(1'b1, mm, 12'h000, 32'h0000_4000);
		@(posedge pclk) freeze <= 1'b1;
		// the port parks only at a transfer boundary, so in-flight work drains first
		for (n = 0; n < 20 && halt !== 1'b1; n++) @(negedge pclk);
		`CHK(halt, 1'b1)
		apb(1'b1, mm, 12'h000, 32'h0000_8000);
		freeze <= 1'b0;
		repeat (2) @(negedge pclk);
		`CHK(run_clk_en, 1'b0)
		`CHK(irq, 1'b1)
		rd(12'h000, 32'h0000_8000);
	endtask
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(negedge pclk);
		t_reset_stop();
		t_levels();
		t_freeze();
		t_sw_stop();
		print_verdict();
	end
endmodule
